// *** rtl/load_adaptive_current_regulator.sv ***
// Load adaptive current regulator: turns full-step load samples into a clamped coil current scale.
// Assumes one 10 MHz clock, a classic Wishbone master, and load samples as one-cycle valid strobes.
`timescale 1ns/1ps
`default_nettype none
`include "current_regulator_regs.svh"
module load_adaptive_current_regulator #(
  parameter int LOAD_W = 10,
  parameter int SCALE_W = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Wishbone slave
  input wire current_regulator_pkg::wb_req_t i_wb,
  output current_regulator_pkg::wb_rsp_t o_wb,
  // Load samples, one per full step
  input wire current_regulator_pkg::load_sample_t i_sample,
  // Regulated coil current scale
  output logic [SCALE_W-1:0] o_regulated_current_level,
  output logic o_coil_enable,
  output logic o_eval_pulse
);
  import current_regulator_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (LOAD_W != 10) begin : g_bad_load
    $error("LOAD_W must be 10");
  end
  if (SCALE_W != 5) begin : g_bad_scale
    $error("SCALE_W must be 5");
  end

  // ==========================================================
  // Helper functions
  // Threshold from a code scaled by 32
  function automatic logic [LOAD_W:0] scale32(input logic [5:0] code);
    scale32 = {code, 5'h00};
  endfunction : scale32

  // Write one byte lane-masked word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ==========================================================
  // Registers
  reg_config_t cfg_q;
  logic [SCALE_W-1:0] scale_limit_q;
  logic configured_q;
  logic [SCALE_W-1:0] level_q;
  logic [5:0] dec_cnt_q;
  logic [1:0] phase_q;
  logic [LOAD_W-1:0] last_sample_q;
  logic [LOAD_W+1:0] acc_q;
  zone_t zone_q;

  // ==========================================================
  // Bus decode
  logic wb_hit;
  logic wb_mapped;
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;
  logic [31:0] lim_new;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign wb_hit = i_wb.cyc && i_wb.stb && !o_wb.ack && !o_wb.err;
  assign wb_mapped = (i_wb.adr == `REG_CONFIG_ADDR) || (i_wb.adr == `REG_LIMIT_ADDR) ||
                     (i_wb.adr == `REG_STATUS_ADDR) || (i_wb.adr == `REG_SAMPLE_ADDR);

  // Pack config into its bus layout
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`CFG_LOWER_LSB +: 4] = cfg_q.lower_load_threshold_code;
    cfg_word[`CFG_WIDTH_LSB +: 4] = cfg_q.upper_window_width;
    cfg_word[`CFG_INC_LSB +: 2] = cfg_q.increment_step_code;
    cfg_word[`CFG_DEC_LSB +: 2] = cfg_q.decrement_rate_code;
    cfg_word[`CFG_FLOOR_BIT] = cfg_q.floor_quarter_choice;
    cfg_word[`CFG_FILTER_BIT] = cfg_q.measurement_filter_enable;
  end

  assign cfg_new = merge(cfg_word, i_wb.dat, i_wb.sel);
  assign lim_new = merge({27'h0000000, scale_limit_q}, i_wb.dat, i_wb.sel);

  // Status shows the actual level, decrement count and filter phase
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STS_LEVEL_LSB +: SCALE_W] = level_q;
    status_word[`STS_DECCNT_LSB +: 6] = dec_cnt_q;
    status_word[`STS_PHASE_LSB +: 2] = phase_q;
  end

  // Read mux
  always_comb begin
    case (i_wb.adr)
      `REG_CONFIG_ADDR: rd_word = cfg_word;
      `REG_LIMIT_ADDR: rd_word = {27'h0000000, scale_limit_q};
      `REG_STATUS_ADDR: rd_word = status_word;
      `REG_SAMPLE_ADDR: rd_word = {22'h000000, last_sample_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: one registered ack the cycle after the request, err on unmapped address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb <= '0;
    end else begin
      o_wb.ack <= wb_hit && wb_mapped;
      o_wb.err <= wb_hit && !wb_mapped;
      o_wb.dat <= (wb_hit && wb_mapped && !i_wb.we) ? rd_word : 32'h0000_0000;
    end
  end

  // Config register writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= '0;
    end else if (wb_hit && i_wb.we && i_wb.adr == `REG_CONFIG_ADDR) begin
      cfg_q.lower_load_threshold_code <= cfg_new[`CFG_LOWER_LSB +: 4];
      cfg_q.upper_window_width <= cfg_new[`CFG_WIDTH_LSB +: 4];
      cfg_q.increment_step_code <= cfg_new[`CFG_INC_LSB +: 2];
      cfg_q.decrement_rate_code <= cfg_new[`CFG_DEC_LSB +: 2];
      cfg_q.floor_quarter_choice <= cfg_new[`CFG_FLOOR_BIT];
      cfg_q.measurement_filter_enable <= cfg_new[`CFG_FILTER_BIT];
    end
  end

  // Scale limit: zero after reset, coil drive only once software writes it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scale_limit_q <= `SCALE_RESET;
      configured_q <= 1'b0;
    end else if (wb_hit && i_wb.we && i_wb.adr == `REG_LIMIT_ADDR && i_wb.sel[0]) begin
      scale_limit_q <= lim_new[`LIM_SCALE_LSB +: SCALE_W];
      configured_q <= 1'b1;
    end
  end

  // ==========================================================
  // Sample path and filter
  logic eval_en;
  logic [LOAD_W-1:0] eval_value;
  logic [LOAD_W+1:0] acc_sum;

  assign acc_sum = acc_q + {2'b00, i_sample.load_measurement};
  // Unfiltered: every sample evaluates; filtered: every fourth, on the mean
  assign eval_en = i_sample.valid && (!cfg_q.measurement_filter_enable || phase_q == 2'(`FILTER_DIV - 1));
  assign eval_value = cfg_q.measurement_filter_enable ? acc_sum[LOAD_W+1:2] : i_sample.load_measurement;

  // Filter phase and accumulator
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= 2'b00;
      acc_q <= '0;
    end else if (!cfg_q.measurement_filter_enable) begin
      phase_q <= 2'b00;
      acc_q <= '0;
    end else if (i_sample.valid) begin
      phase_q <= phase_q + 2'b01;
      acc_q <= eval_en ? '0 : acc_sum;
    end
  end

  // Last raw sample for software
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_sample_q <= '0;
    end else if (i_sample.valid) begin
      last_sample_q <= i_sample.load_measurement;
    end
  end

  // ==========================================================
  // Thresholds and bounds
  logic [LOAD_W:0] lower_thr;
  logic [LOAD_W:0] upper_thr;
  logic [SCALE_W-1:0] floor_lvl;
  logic [SCALE_W:0] inc_step;
  logic [5:0] dec_need;
  zone_t zone_d;

  assign lower_thr = scale32({2'b00, cfg_q.lower_load_threshold_code});
  assign upper_thr = scale32({2'b00, cfg_q.lower_load_threshold_code} +
                             {2'b00, cfg_q.upper_window_width} + 6'h01);
  // Floor as a fraction of the (value+1)/32 limit, kept in the same biased code
  assign floor_lvl = cfg_q.floor_quarter_choice ?
                     SCALE_W'(({1'b0, scale_limit_q} + 6'h01) >> 2) :
                     SCALE_W'(({1'b0, scale_limit_q} + 6'h01) >> 1);
  assign inc_step = 6'h01 << cfg_q.increment_step_code;

  always_comb begin
    case (cfg_q.decrement_rate_code)
      2'h0: dec_need = `DEC_CNT_C0;
      2'h1: dec_need = `DEC_CNT_C1;
      2'h2: dec_need = `DEC_CNT_C2;
      default: dec_need = `DEC_CNT_C3;
    endcase
  end

  // Classify the evaluated sample
  always_comb begin
    if ({1'b0, eval_value} < lower_thr) begin
      zone_d = ZONE_HEAVY;
    end else if ({1'b0, eval_value} >= upper_thr) begin
      zone_d = ZONE_LIGHT;
    end else begin
      zone_d = ZONE_MID;
    end
  end

  // Last classification, kept for debug visibility
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      zone_q <= ZONE_IDLE;
    end else if (eval_en) begin
      zone_q <= zone_d;
    end
  end

  // ==========================================================
  // Regulation of level and decrement counter
  logic [SCALE_W:0] raised;
  logic [SCALE_W-1:0] floor_adj;

  assign raised = {1'b0, level_q} + inc_step;
  // Floor never above the limit, so clamp stays consistent
  assign floor_adj = (floor_lvl > scale_limit_q) ? scale_limit_q : floor_lvl;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= `LEVEL_RESET;
      dec_cnt_q <= 6'h00;
    end else begin
      if (eval_en) begin
        case (zone_d)
          ZONE_HEAVY: begin
            level_q <= (raised > {1'b0, scale_limit_q}) ? scale_limit_q : raised[SCALE_W-1:0];
            dec_cnt_q <= 6'h00;
          end
          ZONE_LIGHT: begin
            if (dec_cnt_q + 6'h01 >= dec_need) begin
              dec_cnt_q <= 6'h00;
              level_q <= (level_q > floor_adj) ? level_q - 5'h01 : floor_adj;
            end else begin
              dec_cnt_q <= dec_cnt_q + 6'h01;
            end
          end
          default: begin
            level_q <= level_q;
          end
        endcase
      end else if (level_q > scale_limit_q) begin
        level_q <= scale_limit_q;
      end else if (level_q < floor_adj) begin
        level_q <= floor_adj;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_regulated_current_level <= `LEVEL_RESET;
      o_coil_enable <= 1'b0;
      o_eval_pulse <= 1'b0;
    end else begin
      o_regulated_current_level <= level_q;
      o_coil_enable <= configured_q;
      o_eval_pulse <= eval_en;
    end
  end
endmodule : load_adaptive_current_regulator
`default_nettype wire

// *** rtl/current_regulator_regs.svh ***
// Constants for the load adaptive current regulator: register map, field layout, reset values.
// Assumes inclusion by the regulator module only.
`ifndef CURRENT_REGULATOR_REGS_SVH
`define CURRENT_REGULATOR_REGS_SVH
// ==========================================================
// Register byte addresses
`define REG_CONFIG_ADDR 4'h0
`define REG_LIMIT_ADDR 4'h4
`define REG_STATUS_ADDR 4'h8
`define REG_SAMPLE_ADDR 4'hC
// ==========================================================
// Config register fields
`define CFG_LOWER_LSB 0
`define CFG_WIDTH_LSB 4
`define CFG_INC_LSB 8
`define CFG_DEC_LSB 10
`define CFG_FLOOR_BIT 12
`define CFG_FILTER_BIT 13
// Limit register field
`define LIM_SCALE_LSB 0
// Status register fields
`define STS_LEVEL_LSB 0
`define STS_DECCNT_LSB 8
`define STS_PHASE_LSB 16
// ==========================================================
// Scaling and counts
`define THRESH_SHIFT 5
`define FILTER_DIV 4
`define DEC_CNT_C0 6'h20
`define DEC_CNT_C1 6'h08
`define DEC_CNT_C2 6'h02
`define DEC_CNT_C3 6'h01
`define SCALE_RESET 5'h00
`define LEVEL_RESET 5'h00
`endif

// *** rtl/current_regulator_pkg.sv ***
// Types shared by the load adaptive current regulator and its bench.
// Assumes the constants header is available on the include path.
package current_regulator_pkg;
  // ==========================================================
  // Regulation settings written by software
  typedef struct packed {
    logic [3:0] lower_load_threshold_code;
    logic [3:0] upper_window_width;
    logic [1:0] increment_step_code;
    logic [1:0] decrement_rate_code;
    logic floor_quarter_choice;
    logic measurement_filter_enable;
  } reg_config_t;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } wb_req_t;
  // Classic Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
  } wb_rsp_t;
  // Load sample from the measurement logic
  typedef struct packed {
    logic valid;
    logic [9:0] load_measurement;
  } load_sample_t;
  // Sample classification
  typedef enum logic [1:0] {
    ZONE_IDLE = 2'b00,
    ZONE_HEAVY = 2'b01,
    ZONE_MID = 2'b10,
    ZONE_LIGHT = 2'b11
  } zone_t;
endpackage : current_regulator_pkg

// *** bench/regulator_checker_properties.sv ***
// Checker for the load adaptive current regulator, bound to its top ports.
// Assumes software writes whole words over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module regulator_checker #(
  parameter int LOAD_W = 10,
  parameter int SCALE_W = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus and samples
  input wire current_regulator_pkg::wb_req_t i_wb,
  input wire current_regulator_pkg::wb_rsp_t o_wb,
  input wire current_regulator_pkg::load_sample_t i_sample,
  // Regulated outputs
  input wire logic [SCALE_W-1:0] o_regulated_current_level,
  input wire logic o_coil_enable,
  input wire logic o_eval_pulse
);
  import current_regulator_pkg::*;
  logic [13:0] cfg_q;
  logic [SCALE_W-1:0] lim_q;
  logic [LOAD_W-1:0] lo;
  logic [LOAD_W-1:0] hi;
  logic take;
  logic hvy;
  logic mid;
  logic req;
  // ==========================================================
  // Shadow of written settings, taken at the acknowledging edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= '0;
      lim_q <= '0;
    end else if (o_wb.ack && i_wb.we && i_wb.adr == 4'h0) begin
      cfg_q <= i_wb.dat[13:0];
    end else if (o_wb.ack && i_wb.we && i_wb.adr == 4'h4) begin
      lim_q <= i_wb.dat[SCALE_W-1:0];
    end
  end
  // Thresholds and sample classes in unfiltered mode
  assign lo = LOAD_W'({cfg_q[3:0], 5'h00});
  assign hi = LOAD_W'((cfg_q[3:0] + cfg_q[7:4] + 10'h001) << 5);
  assign take = i_sample.valid && !cfg_q[13];
  assign hvy = take && i_sample.load_measurement < lo;
  assign mid = take && i_sample.load_measurement >= lo && i_sample.load_measurement < hi;
  assign req = i_wb.cyc && i_wb.stb && !o_wb.ack && !o_wb.err;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_EVAL_LAT: assert property (take |-> ##1 o_eval_pulse)
    else $error("no evaluation pulse after sample");
  AST_HEAVY_UP: assert property (hvy && o_regulated_current_level < lim_q |->
    ##2 o_regulated_current_level > $past(o_regulated_current_level, 2)) else $error("heavy sample did not raise");
  AST_MID_HOLD: assert property (mid |->
    ##2 o_regulated_current_level == $past(o_regulated_current_level, 2)) else $error("mid sample moved level");
  AST_LEVEL_CAP: assert property (o_coil_enable && $past(lim_q, 3) == lim_q |->
    o_regulated_current_level <= lim_q) else $error("level above limit");
  AST_NO_CURRENT: assert property (!o_coil_enable |-> o_regulated_current_level == '0)
    else $error("current before limit written");
  AST_ACK_ONE: assert property (o_wb.ack |=> !o_wb.ack)
    else $error("ack longer than one cycle");
  AST_ACK_LAT: assert property (req |=> o_wb.ack || o_wb.err)
    else $error("bus answer late");
  AST_ERR_MAP: assert property (req && i_wb.adr[1:0] != 2'b00 |=> o_wb.err && !o_wb.ack)
    else $error("unmapped address not refused");
  cover property (hvy);
  cover property (mid);
  cover property (o_wb.err);
endmodule : regulator_checker
bind load_adaptive_current_regulator regulator_checker #(.LOAD_W(LOAD_W), .SCALE_W(SCALE_W)) i_regulator_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb(i_wb), .o_wb(o_wb), .i_sample(i_sample),
  .o_regulated_current_level(o_regulated_current_level), .o_coil_enable(o_coil_enable), .o_eval_pulse(o_eval_pulse));
`default_nettype wire

// *** bench/host_model.sv ***
// Host model: classic Wishbone master for the regulator settings.
// Assumes one caller at a time.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic i_clk,
  // Bus
  output var current_regulator_pkg::wb_req_t o_wb,
  input wire current_regulator_pkg::wb_rsp_t i_wb
);
  import current_regulator_pkg::*;
  initial o_wb = '0;
  // ==========================================================
  // One cycle held until answered; settings precede motor drive
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    // Wait for the answer however long it takes; only the bench watchdog ends a hang
    do begin
      @(posedge i_clk);
    end while (!(i_wb.ack || i_wb.err));
    q = i_wb.dat;
    e = i_wb.err;
    o_wb <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, sel: 4'h0, adr: ~a, dat: ~d};
  endtask : xfer
endmodule : host_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the load adaptive current regulator.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import current_regulator_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  load_sample_t smp = '0;
  logic [4:0] lvl;
  logic en;
  logic pulse;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int checks_done = 0;
  int lv;
  int n;
  // ==========================================================
  // Clock, design and host
  always #50 clk = ~clk;
  load_adaptive_current_regulator i_load_adaptive_current_regulator (.i_clk(clk), .i_rst(rst), .i_wb(wb_req),
    .o_wb(wb_rsp), .i_sample(smp), .o_regulated_current_level(lvl), .o_coil_enable(en), .o_eval_pulse(pulse));
  host_model i_host_model (.i_clk(clk), .o_wb(wb_req), .i_wb(wb_rsp));
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Settings word: lower code 4, window 3
  function automatic logic [31:0] cfg(input int i, input int d, input int q, input int f);
    return {18'h0, f[0], q[0], d[1:0], i[1:0], 8'h34};
  endfunction : cfg
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdw(input logic [3:0] a);
    i_host_model.xfer(1'b0, a, 32'h0, rd, er);
  endtask : rdw
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // One sample, then pulse and level against expectation
  task automatic samp(input logic [9:0] m, input logic p);
    @(posedge clk);
    smp <= '{valid: 1'b1, load_measurement: m};
    @(posedge clk);
    smp <= '{valid: 1'b0, load_measurement: ~m};
    // Pulse follows the taking edge, the level output one edge later
    #1;
    chk(32'(pulse), 32'(p));
    @(posedge clk);
    #1;
    chk(32'(pulse), 32'h0);
    chk(32'(lvl), 32'(lv));
  endtask : samp
  task automatic t_bus;
    chk(32'(en), 32'h0);
    chk(32'(lvl), 32'h0);
    wr(4'h0, cfg(0, 3, 0, 0));
    rdw(4'h0);
    chk(rd, cfg(0, 3, 0, 0));
    rdw(4'h2);
    chk(32'(er), 32'h1);
    settle;
    chk(32'(en), 32'h0);
    wr(4'h4, 32'h1F);
    settle;
    lv = 16;
    chk(32'(en), 32'h1);
    chk(32'(lvl), 32'(lv));
  endtask : t_bus
  task automatic t_up;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, cfg(i, 3, 0, 0));
      lv = (lv + (1 << i) > 31) ? 31 : lv + (1 << i);
      samp(10'h07F, 1'b1);
    end
    rdw(4'h8);
    chk(32'(rd[4:0]), 32'(lv));
    samp(10'h080, 1'b1);
    samp(10'h0FF, 1'b1);
    rdw(4'hC);
    chk(rd, 32'h0000_00FF);
  endtask : t_up
  task automatic t_down;
    for (int d = 3; d >= 0; d--) begin
      n = (d == 0) ? 32 : (d == 1) ? 8 : (d == 2) ? 2 : 1;
      wr(4'h0, cfg(0, d, 0, 0));
      lv = (lv < 31) ? lv + 1 : 31;
      samp(10'h000, 1'b1);
      for (int k = 1; k <= n; k++) begin
        if (k == n) begin
          samp(10'h0C8, 1'b1);
          lv--;
        end
        samp(10'h100, 1'b1);
      end
    end
  endtask : t_down
  task automatic t_filt;
    wr(4'h0, cfg(3, 3, 0, 1));
    repeat (3) samp(10'h064, 1'b0);
    lv = (lv + 8 > 31) ? 31 : lv + 8;
    samp(10'h064, 1'b1);
  endtask : t_filt
  task automatic t_floor;
    wr(4'h0, cfg(0, 3, 1, 0));
    for (int j = 0; j < 26; j++) begin
      lv = (lv > 8) ? lv - 1 : 8;
      samp(10'h12C, 1'b1);
    end
    wr(4'h0, cfg(0, 3, 0, 0));
    settle;
    chk(32'(lvl), 32'h10);
    wr(4'h4, 32'h07);
    settle;
    chk(32'(lvl), 32'h07);
  endtask : t_floor
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_bus;
    t_up;
    t_down;
    t_filt;
    t_floor;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
